// file: common/twm_defines.svh
// twm_defines.svh: register offsets, field positions, resets, top values and limits
// assumes: included by bare name from the design and verification files
`ifndef TWM_DEFINES_SVH
`define TWM_DEFINES_SVH
// register byte offsets on the ahb-lite slave
`define TWM_OFS_CTRL_A    12'h000
`define TWM_OFS_CTRL_B    12'h004
`define TWM_OFS_COUNT     12'h008
`define TWM_OFS_CMP_A     12'h00c
`define TWM_OFS_CMP_B     12'h010
`define TWM_OFS_CAPTURE   12'h014
`define TWM_OFS_TICK_DIV  12'h018
`define TWM_OFS_STATUS    12'h01c
`define TWM_OFS_PORT_DIR  12'h020
// control a fields
`define TWM_A_ACT_A_HI    7
`define TWM_A_ACT_A_LO    6
`define TWM_A_ACT_B_HI    5
`define TWM_A_ACT_B_LO    4
`define TWM_A_MODE_HI     1
`define TWM_A_MODE_LO     0
// control b fields
`define TWM_B_MODE_HI     4
`define TWM_B_MODE_LO     3
// reset values
`define TWM_RST_CTRL      8'h00
`define TWM_RST_DIV       16'h0000
// fixed top values and limits
`define TWM_TOP_8BIT      16'h00ff
`define TWM_TOP_9BIT      16'h01ff
`define TWM_TOP_10BIT     16'h03ff
`define TWM_MAX           16'hffff
`define TWM_BOTTOM        16'h0000
`endif

// file: common/twm_pkg.sv
// twm_pkg.sv: types for the timer waveform-mode block
// assumes: twm_defines.svh on the include path
package twm_pkg;
	// waveform mode field codes
	typedef enum logic [3:0] {
		TWM_NORMAL     = 4'h0,
		TWM_PC8        = 4'h1,
		TWM_PC9        = 4'h2,
		TWM_PC10       = 4'h3,
		TWM_CTC_CMP    = 4'h4,
		TWM_FAST8      = 4'h5,
		TWM_FAST9      = 4'h6,
		TWM_FAST10     = 4'h7,
		TWM_PFC_CAP    = 4'h8,
		TWM_PFC_CMP    = 4'h9,
		TWM_PC_CAP     = 4'ha,
		TWM_PC_CMP     = 4'hb,
		TWM_CTC_CAP    = 4'hc,
		TWM_RESERVED   = 4'hd,
		TWM_FAST_CAP   = 4'he,
		TWM_FAST_CMP   = 4'hf
	} twm_mode_e;
	// waveform family derived from the mode
	typedef enum logic [1:0] {
		TWM_FAM_NONPWM = 2'h0,
		TWM_FAM_FAST   = 2'h1,
		TWM_FAM_DUAL   = 2'h2,
		TWM_FAM_NONE   = 2'h3
	} twm_family_e;
	// per-unit action picked for one tick
	typedef enum logic [1:0] {
		TWM_ACT_HOLD   = 2'h0,
		TWM_ACT_TOGGLE = 2'h1,
		TWM_ACT_CLEAR  = 2'h2,
		TWM_ACT_SET    = 2'h3
	} twm_act_e;
	// bus slave states
	typedef enum logic [1:0] {
		TWM_BUS_IDLE   = 2'h0,
		TWM_BUS_WRITE  = 2'h1,
		TWM_BUS_READ   = 2'h2
	} twm_bus_e;
endpackage

// file: src/twm_unit.sv
// twm_unit.sv: one compare-output unit (match, buffer, waveform, pin)
// assumes: driven by the timer core on hclk, tick as a clock enable
`include "twm_defines.svh"
module twm_unit #(
	parameter int W = 16            // counter width
) (
	input  wire logic         hclk,        // system clock
	input  wire logic         hresetn,     // async reset, low active
	input  wire logic         tick,        // timer tick enable
	input  wire logic [1:0]   act_field,   // unit output action field
	input  wire logic [1:0]   family,      // waveform family
	input  wire logic         toggle_ok,   // field 01 allowed to toggle
	input  wire logic         load_now,    // copy buffer into active
	input  wire logic         immediate,   // buffer bypassed
	input  wire logic         buf_wr,      // software writes the buffer
	input  wire logic [W-1:0] buf_data,    // value written
	input  wire logic [W-1:0] top,         // current top value
	input  wire logic [W-1:0] count,       // counter value
	input  wire logic         at_top,      // counter sits at top
	input  wire logic         down,        // dual slope counting down
	input  wire logic         dir_out,     // port direction is output
	input  wire logic         port_data,   // normal port function level
	input  wire logic         flag_clr,    // software clears match flag
	output logic [W-1:0]      active,      // active compare value
	output logic              match_flag,  // sticky compare-match flag
	output logic              pin_o,       // pin level
	output logic              pin_oe_n     // pin driver enable, low on
);
	////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [W-1:0] buf_v;   // buffered compare value
		logic [W-1:0] act_v;   // active compare value
		logic         wave;    // waveform register
		logic         flag;    // match flag
	} twm_unit_s;
	twm_unit_s st_r;            // registered state
	twm_unit_s st_nxt;          // next state
	logic      match;           // count equals active compare
	logic      ovr;             // waveform overrides port
	logic      dn;              // slope seen by a match
	twm_pkg::twm_act_e act;     // action this tick

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_nxt = st_r;
		act    = twm_pkg::TWM_ACT_HOLD;
		match  = (count == st_r.act_v);
		dn     = at_top || (down && count != '0);
		// buffer write; immediate modes update the active value too
		if (buf_wr) begin
			st_nxt.buf_v = buf_data;
			if (immediate) begin
				st_nxt.act_v = buf_data;
			end
		end
		if (tick) begin
			if (match) begin
				st_nxt.flag = 1'b1;
			end
			case (twm_pkg::twm_family_e'(family))
				twm_pkg::TWM_FAM_NONPWM: begin
					// match actions by field
					if (match) begin
						act = twm_pkg::twm_act_e'(act_field);
					end
				end
				twm_pkg::TWM_FAM_FAST: begin
					if (act_field == 2'b01) begin
						if (match && toggle_ok) begin
							act = twm_pkg::TWM_ACT_TOGGLE;
						end
					end else if (act_field[1]) begin
						// top action wins; match at top ignored
						if (at_top) begin
							act = act_field[0] ? twm_pkg::TWM_ACT_CLEAR
								: twm_pkg::TWM_ACT_SET;
						end else if (match) begin
							act = act_field[0] ? twm_pkg::TWM_ACT_SET
								: twm_pkg::TWM_ACT_CLEAR;
						end
					end
				end
				twm_pkg::TWM_FAM_DUAL: begin
					if (act_field == 2'b01) begin
						if (match && toggle_ok) begin
							act = twm_pkg::TWM_ACT_TOGGLE;
						end
					end else if (act_field[1] && match) begin
						// up clears, down sets for field 10
						if (dn ^ act_field[0]) begin
							act = twm_pkg::TWM_ACT_SET;
						end else begin
							act = twm_pkg::TWM_ACT_CLEAR;
						end
					end else if (act_field[1] && at_top
						&& st_r.act_v > top) begin
						// value above top never matches: hold the rail
						act = act_field[0] ? twm_pkg::TWM_ACT_CLEAR
							: twm_pkg::TWM_ACT_SET;
					end
				end
				default: begin
					act = twm_pkg::TWM_ACT_HOLD;
				end
			endcase
			if (load_now && !immediate) begin
				st_nxt.act_v = st_r.buf_v;
			end
		end
		case (act)
			twm_pkg::TWM_ACT_TOGGLE: st_nxt.wave = ~st_r.wave;
			twm_pkg::TWM_ACT_CLEAR:  st_nxt.wave = 1'b0;
			twm_pkg::TWM_ACT_SET:    st_nxt.wave = 1'b1;
			default:                 st_nxt.wave = st_r.wave;
		endcase
		// set wins over clear
		if (flag_clr && !(tick && match)) begin
			st_nxt.flag = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin mux: override by field, driver by direction only
	assign ovr        = |act_field;
	assign pin_o      = ovr ? st_r.wave : port_data;
	assign pin_oe_n   = ~dir_out;
	assign active     = st_r.act_v;
	assign match_flag = st_r.flag;
endmodule

// file: src/twm_timer.sv
// twm_timer.sv: 16-bit timer with waveform-mode and compare-output control
// assumes: one ahb-lite master, single word transfers, hclk 100 MHz
//
// Contract
// - synchronous on hclk, tick is clock enable
// - dual-frequency modes load compare at bottom
// - nonzero action field overrides port function
// - pin driver enabled only by direction bit
// - non-pwm: off, toggle, clear, set on match
// - fast field 01 toggles unit a, modes 14/15
// - fast: 10 clear-match set-top, 11 inverse
// - fast: compare equals top, only top action
// - dual field 01 toggles unit a, modes 8-11
// - dual: 10 clear up set down, 11 inverse
// - mode field: two bits a, two bits b
// - phase correct tops, load top, overflow bottom
// - fast tops, load top, overflow top
// - modes 8/9 top, load and overflow bottom
// - normal and ctc: immediate update, overflow max
// - bottom events mirror top timing
// - bottom is zero; dual slope up then down
// - match flag set when count equals compare
// - dual: compare bottom low, top high
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`include "twm_defines.svh"
module twm_timer #(
	parameter int W = 16                // counter width
) (
	input  wire logic        hclk,       // system clock
	input  wire logic        hresetn,    // async reset, low active
	input  wire logic        hsel,       // slave select
	input  wire logic [31:0] haddr,      // address
	input  wire logic [1:0]  htrans,     // transfer type
	input  wire logic        hwrite,     // write when high
	input  wire logic [2:0]  hsize,      // transfer size
	input  wire logic        hready,     // bus ready in
	input  wire logic [31:0] hwdata,     // write data
	output logic [31:0]      hrdata,     // read data
	output logic             hreadyout,  // slave ready
	output logic             hresp,      // response, always okay
	input  wire logic [1:0]  port_data,  // normal port levels b,a
	output logic             wave_out_a,      // unit a pin level
	output logic             wave_out_a_oe_n, // unit a driver, low on
	output logic             wave_out_b,      // unit b pin level
	output logic             wave_out_b_oe_n, // unit b driver, low on
	output logic             overflow_flag    // sticky overflow flag
);
	////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic [7:0]   ctrl_a;    // output actions and low mode bits
		logic [7:0]   ctrl_b;    // high mode bits
		logic [W-1:0] count;     // counter value
		logic [W-1:0] capture;   // capture register
		logic [15:0]  div;       // tick divider reload
		logic [15:0]  pre;       // tick divider count
		logic         down;      // dual slope counting down
		logic [1:0]   dir;       // port direction bits b,a
		logic         ovf;       // overflow flag
		twm_pkg::twm_bus_e bus;  // pending data phase
		logic [11:0]  addr;      // latched address
		logic [31:0]  rdata;     // read data register
	} twm_s;
	twm_s st_r;                      // registered state
	twm_s st_nxt;                    // next state

	twm_pkg::twm_mode_e   mode;      // waveform mode field
	twm_pkg::twm_family_e fam;       // waveform family
	logic [W-1:0] top;               // current top
	logic [W-1:0] cmp_a;             // active compare a
	logic [W-1:0] cmp_b;             // active compare b
	logic [1:0]   flag_m;            // match flags b,a
	logic         tick;              // timer tick enable
	logic         at_top;            // counter equals top
	logic         at_bot;            // counter at bottom
	logic         load_top;          // buffers load at top
	logic         ovf_top;           // overflow raised at top
	logic         dual;              // dual-slope mode
	logic         imm;               // immediate compare update
	logic         tog_ok;            // field 01 toggles unit a
	logic         load_now;          // buffer load this tick
	logic         ovf_set;           // overflow event this tick
	logic         wr_cmp_a;          // write compare a buffer
	logic         wr_cmp_b;          // write compare b buffer
	logic         wr_cnt;            // write counter
	logic         clr_a;             // clear match flag a
	logic         clr_b;             // clear match flag b
	logic         addr_ph;           // valid address phase
	logic [W-1:0] wdata_w;           // write data, counter width

	////////////////////////////////////////////////////////////////////
	// mode decode
	always_comb begin
		mode = twm_pkg::twm_mode_e'({st_r.ctrl_b[`TWM_B_MODE_HI:`TWM_B_MODE_LO],
			st_r.ctrl_a[`TWM_A_MODE_HI:`TWM_A_MODE_LO]});
		top      = `TWM_MAX;
		fam      = twm_pkg::TWM_FAM_NONPWM;
		dual     = 1'b0;
		load_top = 1'b1;
		ovf_top  = 1'b0;
		imm      = 1'b0;
		tog_ok   = 1'b0;
		case (mode)
			twm_pkg::TWM_NORMAL, twm_pkg::TWM_CTC_CMP,
			twm_pkg::TWM_CTC_CAP: begin
				imm = 1'b1;
				if (mode == twm_pkg::TWM_CTC_CMP) begin
					top = cmp_a;
				end else if (mode == twm_pkg::TWM_CTC_CAP) begin
					top = st_r.capture;
				end
			end
			twm_pkg::TWM_PC8, twm_pkg::TWM_PC9, twm_pkg::TWM_PC10,
			twm_pkg::TWM_PC_CAP, twm_pkg::TWM_PC_CMP: begin
				fam  = twm_pkg::TWM_FAM_DUAL;
				dual = 1'b1;
				case (mode)
					twm_pkg::TWM_PC8:    top = `TWM_TOP_8BIT;
					twm_pkg::TWM_PC9:    top = `TWM_TOP_9BIT;
					twm_pkg::TWM_PC10:   top = `TWM_TOP_10BIT;
					twm_pkg::TWM_PC_CAP: top = st_r.capture;
					default:             top = cmp_a;
				endcase
				tog_ok = (mode == twm_pkg::TWM_PC_CAP)
					|| (mode == twm_pkg::TWM_PC_CMP);
			end
			twm_pkg::TWM_PFC_CAP, twm_pkg::TWM_PFC_CMP: begin
				fam      = twm_pkg::TWM_FAM_DUAL;
				dual     = 1'b1;
				load_top = 1'b0;
				tog_ok   = 1'b1;
				top = (mode == twm_pkg::TWM_PFC_CAP) ? st_r.capture : cmp_a;
			end
			twm_pkg::TWM_FAST8, twm_pkg::TWM_FAST9, twm_pkg::TWM_FAST10,
			twm_pkg::TWM_FAST_CAP, twm_pkg::TWM_FAST_CMP: begin
				fam     = twm_pkg::TWM_FAM_FAST;
				ovf_top = 1'b1;
				case (mode)
					twm_pkg::TWM_FAST8:    top = `TWM_TOP_8BIT;
					twm_pkg::TWM_FAST9:    top = `TWM_TOP_9BIT;
					twm_pkg::TWM_FAST10:   top = `TWM_TOP_10BIT;
					twm_pkg::TWM_FAST_CAP: top = st_r.capture;
					default:               top = cmp_a;
				endcase
				tog_ok = (mode == twm_pkg::TWM_FAST_CAP)
					|| (mode == twm_pkg::TWM_FAST_CMP);
			end
			default: begin
				fam = twm_pkg::TWM_FAM_NONE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// tick, turning points and events
	assign tick   = (st_r.pre == st_r.div);
	assign at_top = (st_r.count == top);
	assign at_bot = (st_r.count == `TWM_BOTTOM);
	// bottom events only on the turn, mirroring the top events
	assign load_now = tick && (load_top ? at_top : (at_bot && st_r.down));
	assign ovf_set  = tick && (imm ? (st_r.count == `TWM_MAX)
		: ovf_top ? at_top : (at_bot && st_r.down));
	assign addr_ph  = hsel && hready && htrans[1];
	assign wdata_w  = hwdata[W-1:0];
	assign wr_cmp_a = (st_r.bus == twm_pkg::TWM_BUS_WRITE)
		&& (st_r.addr == `TWM_OFS_CMP_A);
	assign wr_cmp_b = (st_r.bus == twm_pkg::TWM_BUS_WRITE)
		&& (st_r.addr == `TWM_OFS_CMP_B);
	assign wr_cnt   = (st_r.bus == twm_pkg::TWM_BUS_WRITE)
		&& (st_r.addr == `TWM_OFS_COUNT);
	assign clr_a    = (st_r.bus == twm_pkg::TWM_BUS_WRITE)
		&& (st_r.addr == `TWM_OFS_STATUS) && hwdata[1];
	assign clr_b    = (st_r.bus == twm_pkg::TWM_BUS_WRITE)
		&& (st_r.addr == `TWM_OFS_STATUS) && hwdata[2];

	////////////////////////////////////////////////////////////////////
	// next state: counter, registers, bus
	always_comb begin
		st_nxt = st_r;
		// tick divider: one enable pulse every div+1 cycles
		st_nxt.pre = tick ? 16'h0000 : st_r.pre + 16'h0001;
		if (tick && fam != twm_pkg::TWM_FAM_NONE) begin
			if (dual) begin
				// up to top, then back down to bottom
				if (!st_r.down) begin
					if (st_r.count >= top) begin
						st_nxt.down  = 1'b1;
						st_nxt.count = st_r.count - 16'h0001;
					end else begin
						st_nxt.count = st_r.count + 16'h0001;
					end
				end else if (at_bot) begin
					st_nxt.down  = 1'b0;
					st_nxt.count = st_r.count + 16'h0001;
				end else begin
					st_nxt.count = st_r.count - 16'h0001;
				end
			end else begin
				st_nxt.down  = 1'b0;
				st_nxt.count = at_top ? `TWM_BOTTOM
					: st_r.count + 16'h0001;
			end
		end
		// overflow: set wins over software clear
		if (ovf_set) begin
			st_nxt.ovf = 1'b1;
		end else if ((st_r.bus == twm_pkg::TWM_BUS_WRITE)
			&& (st_r.addr == `TWM_OFS_STATUS) && hwdata[0]) begin
			st_nxt.ovf = 1'b0;
		end
		// data phase of a write
		if (st_r.bus == twm_pkg::TWM_BUS_WRITE) begin
			case (st_r.addr)
				`TWM_OFS_CTRL_A:   st_nxt.ctrl_a  = hwdata[7:0] & 8'hf3;
				`TWM_OFS_CTRL_B:   st_nxt.ctrl_b  = hwdata[7:0] & 8'h18;
				`TWM_OFS_COUNT:    st_nxt.count   = wdata_w;
				`TWM_OFS_CAPTURE:  st_nxt.capture = wdata_w;
				`TWM_OFS_TICK_DIV: begin
					st_nxt.div = hwdata[15:0];
					st_nxt.pre = 16'h0000;
				end
				`TWM_OFS_PORT_DIR: st_nxt.dir     = hwdata[1:0];
				default:           st_nxt.dir     = st_nxt.dir;
			endcase
		end
		// address phase
		st_nxt.bus = twm_pkg::TWM_BUS_IDLE;
		if (addr_ph) begin
			st_nxt.bus  = hwrite ? twm_pkg::TWM_BUS_WRITE
				: twm_pkg::TWM_BUS_READ;
			st_nxt.addr = haddr[11:0];
			st_nxt.rdata = 32'h0000_0000;
			case (haddr[11:0])
				`TWM_OFS_CTRL_A:   st_nxt.rdata[7:0]   = st_r.ctrl_a;
				`TWM_OFS_CTRL_B:   st_nxt.rdata[7:0]   = st_r.ctrl_b;
				`TWM_OFS_COUNT:    st_nxt.rdata[W-1:0] = st_r.count;
				`TWM_OFS_CMP_A:    st_nxt.rdata[W-1:0] = cmp_a;
				`TWM_OFS_CMP_B:    st_nxt.rdata[W-1:0] = cmp_b;
				`TWM_OFS_CAPTURE:  st_nxt.rdata[W-1:0] = st_r.capture;
				`TWM_OFS_TICK_DIV: st_nxt.rdata[15:0]  = st_r.div;
				`TWM_OFS_STATUS:   st_nxt.rdata[3:0]   = {st_r.down,
					flag_m, st_r.ovf};
				`TWM_OFS_PORT_DIR: st_nxt.rdata[1:0]   = st_r.dir;
				default:           st_nxt.rdata        = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r        <= '0;
			st_r.ctrl_a <= `TWM_RST_CTRL;
			st_r.ctrl_b <= `TWM_RST_CTRL;
			st_r.div    <= `TWM_RST_DIV;
			st_r.bus    <= twm_pkg::TWM_BUS_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// compare units
	twm_unit #(.W(W)) u_unit_a (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.tick      (tick && !wr_cnt),
		.act_field (st_r.ctrl_a[`TWM_A_ACT_A_HI:`TWM_A_ACT_A_LO]),
		.family    (fam),
		.toggle_ok (tog_ok),
		.load_now  (load_now),
		.immediate (imm),
		.buf_wr    (wr_cmp_a),
		.buf_data  (wdata_w),
		.top       (top),
		.count     (st_r.count),
		.at_top    (at_top),
		.down      (st_r.down),
		.dir_out   (st_r.dir[0]),
		.port_data (port_data[0]),
		.flag_clr  (clr_a),
		.active    (cmp_a),
		.match_flag(flag_m[0]),
		.pin_o     (wave_out_a),
		.pin_oe_n  (wave_out_a_oe_n)
	);
	// unit b toggles on field 01 only in non-pwm modes
	twm_unit #(.W(W)) u_unit_b (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.tick      (tick && !wr_cnt),
		.act_field (st_r.ctrl_a[`TWM_A_ACT_B_HI:`TWM_A_ACT_B_LO]),
		.family    (fam),
		.toggle_ok (1'b0),
		.load_now  (load_now),
		.immediate (imm),
		.buf_wr    (wr_cmp_b),
		.buf_data  (wdata_w),
		.top       (top),
		.count     (st_r.count),
		.at_top    (at_top),
		.down      (st_r.down),
		.dir_out   (st_r.dir[1]),
		.port_data (port_data[1]),
		.flag_clr  (clr_b),
		.active    (cmp_b),
		.match_flag(flag_m[1]),
		.pin_o     (wave_out_b),
		.pin_oe_n  (wave_out_b_oe_n)
	);

	////////////////////////////////////////////////////////////////////
	// bus outputs: zero wait states, always okay
	assign hrdata        = st_r.rdata;
	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign overflow_flag = st_r.ovf;
endmodule

// file: verification/twm_timer_properties.sv
// twm_timer_properties.sv: port checks for the timer waveform block
// assumes: bound to twm_timer, control bits shadowed from bus writes
`include "twm_defines.svh"
module twm_timer_properties (
	input wire logic        hclk,            // clock
	input wire logic        hresetn,         // async reset, low
	input wire logic        hsel,            // slave select
	input wire logic [31:0] haddr,           // address
	input wire logic [1:0]  htrans,          // transfer type
	input wire logic        hwrite,          // write strobe
	input wire logic        hready,          // bus ready
	input wire logic [31:0] hwdata,          // write data
	input wire logic [1:0]  port_data,       // normal port levels
	input wire logic        wave_out_a,      // unit a level
	input wire logic        wave_out_a_oe_n, // unit a driver
	input wire logic        wave_out_b,      // unit b level
	input wire logic        wave_out_b_oe_n, // unit b driver
	input wire logic        overflow_flag    // overflow flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        wv_r;  // write data phase due
	logic [11:0] wa_r;  // its address
	logic [7:0]  ca_r;  // shadow control a
	logic [1:0]  mh_r;  // shadow mode high bits
	logic [1:0]  dir_r; // shadow direction bits
	logic [1:0]  age_r; // cycles since a control write
	logic [3:0]  mode;  // shadow mode field
	logic        cw;    // control write lands now
	assign mode = {mh_r, ca_r[1:0]};
	assign cw = wv_r && (wa_r == `TWM_OFS_CTRL_A || wa_r == `TWM_OFS_CTRL_B);
	// follow register writes in their data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wv_r <= 1'b0;
			wa_r <= 12'h000;
			ca_r <= 8'h00;
			mh_r <= 2'h0;
			dir_r <= 2'h0;
			age_r <= 2'h0;
		end else begin
			wv_r <= hsel && hready && htrans[1] && hwrite;
			wa_r <= haddr[11:0];
			if (wv_r && wa_r == `TWM_OFS_CTRL_A)
				ca_r <= hwdata[7:0];
			if (wv_r && wa_r == `TWM_OFS_CTRL_B)
				mh_r <= hwdata[4:3];
			if (wv_r && wa_r == `TWM_OFS_PORT_DIR)
				dir_r <= hwdata[1:0];
			// saturating settle count, pending wave updates drain
			age_r <= cw ? 2'h0 : (age_r == 2'h3 ? age_r : age_r + 2'h1);
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	pass_a_a: assert property (ca_r[7:6] == 2'h0 |-> wave_out_a == port_data[0])
		else $error("unit a pin not on port level");
	pass_b_a: assert property (ca_r[5:4] == 2'h0 |-> wave_out_b == port_data[1])
		else $error("unit b pin not on port level");
	drv_a_a: assert property (wave_out_a_oe_n == !dir_r[0])
		else $error("unit a driver enable wrong");
	drv_b_a: assert property (wave_out_b_oe_n == !dir_r[1])
		else $error("unit b driver enable wrong");
	fast_hold_a: assert property (age_r == 2'h3 && ca_r[7:6] == 2'h1 && mode inside {twm_pkg::TWM_FAST8, twm_pkg::TWM_FAST9, twm_pkg::TWM_FAST10} |=> $stable(wave_out_a))
		else $error("unit a toggled in short fast mode");
	dual_hold_a: assert property (age_r == 2'h3 && ca_r[5:4] == 2'h1 && mode inside {[4'h1:4'h3], [4'h8:4'hb]} |-> $stable(wave_out_b))
		else $error("unit b toggled in dual mode");
	rsv_hold_a: assert property (age_r == 2'h3 && mode == twm_pkg::TWM_RESERVED && ca_r[7:6] != 2'h0 && ca_r[5:4] != 2'h0 |-> $stable(wave_out_a) && $stable(wave_out_b))
		else $error("outputs moved in reserved mode");
	ovf_clear_a: assert property ($fell(overflow_flag) |-> $past(wv_r && wa_r == `TWM_OFS_STATUS && hwdata[0]))
		else $error("overflow flag dropped unasked");
	cover property (age_r == 2'h3 && mode == twm_pkg::TWM_PFC_CAP);
	cover property ($fell(overflow_flag));
	cover property (age_r == 2'h3 && mode == twm_pkg::TWM_RESERVED);
endmodule
bind twm_timer twm_timer_properties twm_timer_properties_i (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .port_data,
	.wave_out_a, .wave_out_a_oe_n, .wave_out_b, .wave_out_b_oe_n,
	.overflow_flag);

// file: verification/twm_pin_model.sv
// twm_pin_model.sv: pad of one waveform pin, pulled up when released
// assumes: block drives a level and an active-low driver enable
module twm_pin_model (
	input  wire logic lvl,  // level from the block
	input  wire logic oe_n, // driver enable, low on
	output logic      pad   // resolved pad level
);
	timeunit 1ns;
	timeprecision 1ps;
	// released pad rises to the pull-up level
	assign pad = oe_n ? 1'b1 : lvl;
endmodule

// file: verification/tb.sv
// tb.sv: self-checking bench for the timer waveform block
// assumes: design, checker and pin model compiled before it
`include "twm_defines.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk, hresetn, hsel, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans, port_data;
	logic [2:0]  hsize;
	logic        wa, wa_n, wb, wb_n, ovf, pad_a, pad_b;
	logic [15:0] lf;        // random source
	int          bad_count; // mismatches
	int          checks;    // comparisons
	int          n;         // wait count
	logic [11:0] zofs [5];  // places that read zero after reset
	twm_timer twm_timer_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hready, .hwdata, .hrdata, .hreadyout(hready), .hresp,
		.port_data, .wave_out_a(wa), .wave_out_a_oe_n(wa_n),
		.wave_out_b(wb), .wave_out_b_oe_n(wb_n), .overflow_flag(ovf));
	twm_pin_model twm_pin_model_a_i (.lvl(wa), .oe_n(wa_n), .pad(pad_a));
	twm_pin_model twm_pin_model_b_i (.lvl(wb), .oe_n(wb_n), .pad(pad_b));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	function automatic logic [15:0] nxt(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic int rn(int t);
		return int'(lf) % t;
	endfunction
	// random port levels each cycle
	always @(posedge hclk) begin
		lf <= nxt(lf);
		port_data <= lf[1:0];
	end
	// high cycles over two periods; fam 0 ctc, 1 fast, 2 dual
	function automatic int ehigh(int fam, int f, int c, int p);
		int h;
		if (f == 1)
			return p;
		h = (fam == 0) ? 0 : (fam == 1) ? 2 * (c + 1) : 4 * c;
		return (f == 2) ? h : 2 * p - h;
	endfunction
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic wait_rdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hready !== 1'b1 && k < 64);
		if (hready !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t: bus hang", $time);
			end_sim;
		end
	endtask
	// one single-word transfer, address then data phase
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// set a mode, settle, then count pad high cycles over two periods
	task automatic run_cfg(input int md, fam, top, fa, fb, ca, cb, sk);
		int p, ha, hb;
		p = (fam == 2) ? 2 * top : top + 1;
		wr(`TWM_OFS_CTRL_A, (fa << 6) | (fb << 4) | (md & 3));
		wr(`TWM_OFS_CTRL_B, (md >> 2) << 3);
		wr(`TWM_OFS_CAPTURE, top);
		wr(`TWM_OFS_CMP_A, ca);
		wr(`TWM_OFS_CMP_B, cb);
		wr(`TWM_OFS_COUNT, 0);
		ha = 0;
		hb = 0;
		repeat (2 * p + 1024) @(posedge hclk);
		repeat (2 * p) begin
			@(posedge hclk);
			ha += pad_a;
			hb += pad_b;
		end
		if (!sk[0])
			chk(ha, ehigh(fam, fa, ca, p));
		if (!sk[1])
			chk(hb, ehigh(fam, fb, cb, p));
		$display("test mode %0d done", md);
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		port_data = 2'h0;
		lf = 16'h0053;
		bad_count = 0;
		checks = 0;
		zofs = '{`TWM_OFS_CTRL_A, `TWM_OFS_CTRL_B, `TWM_OFS_TICK_DIV,
			`TWM_OFS_PORT_DIR, 12'h100};
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		chk({pad_a, pad_b, ovf, hresp}, 32'hc);
		foreach (zofs[i])
			rd(zofs[i], 32'h0);
		wr(`TWM_OFS_CTRL_A, 32'hff);
		rd(`TWM_OFS_CTRL_A, 32'hf3);
		wr(`TWM_OFS_CTRL_B, 32'hff);
		rd(`TWM_OFS_CTRL_B, 32'h18);
		wr(`TWM_OFS_CTRL_A, 32'h0);
		wr(`TWM_OFS_CTRL_B, 32'h0);
		wr(`TWM_OFS_PORT_DIR, 32'h3);
		#1 chk({wa_n, wb_n}, 32'h0);
		@(posedge hclk);
		wr(`TWM_OFS_COUNT, 32'hfff0);
		n = 0;
		while (ovf !== 1'b1 && n < 40) begin
			@(posedge hclk);
			#1 n++;
		end
		chk(n, 16);
		@(posedge hclk);
		wr(`TWM_OFS_STATUS, 32'h1);
		#1 chk(ovf, 32'h0);
		@(posedge hclk);
		rd(`TWM_OFS_STATUS, 32'h6);
		$display("test registers done");
		run_cfg(5, 1, 255, 2, 3, rn(255), rn(255), 0);
		run_cfg(6, 1, 511, 3, 2, 511, rn(511), 0);
		run_cfg(7, 1, 1023, 2, 3, 1023, 0, 0);
		run_cfg(15, 1, 127, 1, 2, 127, 127, 0);
		run_cfg(14, 1, 99, 1, 3, 40, 60, 0);
		run_cfg(5, 1, 255, 1, 2, 9, rn(255), 1);
		run_cfg(1, 2, 255, 2, 3, rn(255), rn(255), 0);
		run_cfg(3, 2, 1023, 3, 2, 0, 1023, 0);
		run_cfg(8, 2, 128, 2, 2, 0, 128, 0);
		run_cfg(10, 2, 100, 1, 3, 100, 30, 0);
		run_cfg(11, 2, 80, 1, 1, 80, 20, 2);
		run_cfg(4, 0, 63, 1, 3, 63, 63, 0);
		run_cfg(12, 0, 50, 2, 1, 50, 50, 0);
		run_cfg(13, 0, 64, 2, 3, 0, 0, 3);
		end_sim;
	end
endmodule
